// ---- rtl/overtravel_input_mapper_map.svh ----
// Register offsets, field positions, reset values and selector codes of the overtravel input mapper.
`ifndef OVERTRAVEL_INPUT_MAPPER_MAP_SVH
`define OVERTRAVEL_INPUT_MAPPER_MAP_SVH
`define OIM_OFF_SEL_SECOND 4'h0
`define OIM_OFF_SEL_THIRD 4'h4
`define OIM_OFF_ACT_SECOND 4'h8
`define OIM_OFF_ACT_THIRD 4'hc
`define OIM_RST_SEL_SECOND 16'h8882
`define OIM_RST_SEL_THIRD 16'h8888
`define OIM_REV_DIGIT_LSB 0
`define OIM_REV_DIGIT_MSB 3
`define OIM_CODE_LOW_LAST 4'h6
`define OIM_CODE_FORCE_ON 4'h7
`define OIM_CODE_FORCE_OFF 4'h8
`define OIM_CODE_HIGH_FIRST 4'h9
`define OIM_TERM_COUNT 7
`endif

// ---- rtl/overtravel_input_mapper_pkg.sv ----
// Types shared by the overtravel input mapper.
package overtravel_input_mapper_pkg;
	// Pair of input-selection parameters that travel together.
	typedef struct packed {
		logic [15:0] second;
		logic [15:0] third;
	} input_select_t;
	// Sequencer of the mapper after a power cycle.
	typedef enum logic [0:0] {
		ST_LOAD,
		ST_RUN
	} map_state_t;
endpackage

// ---- rtl/overtravel_input_mapper.sv ----
// Overtravel input mapper: selection parameters, staged activation and reverse limit routing.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "overtravel_input_mapper_map.svh"

// Summary of operation
// - Second selection parameter defaults 8882, low digit.
// - Codes 0-6 route terminal, active low.
// - Codes 9-F route terminal, active high.
// - Third selection parameter defaults 8888, reserved.
// - New values apply only on set-up command.
// - Stored values apply after power cycle.
module overtravel_input_mapper
	import overtravel_input_mapper_pkg::*;
(
	input wire logic mclk, // System clock, 100 MHz.
	input wire logic reset_n, // Synchronous reset, models a power cycle.
	input wire logic por_n, // Synchronous init of the nonvolatile store.
	input wire logic [3:0] reg_addr, // Register byte address.
	input wire logic [15:0] reg_wdata, // Register write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [15:0] reg_rdata, // Read data, one cycle after the strobe.
	input wire logic setup_device_cmd, // Set-up-device command pulse.
	input wire logic nonvolatile_param_write_cmd, // Nonvolatile store command pulse.
	input wire logic [6:0] io_connector_terminals, // General-purpose input terminal levels.
	output logic reverse_travel_limit // Reverse overtravel signal, high when active.
);

	// Written values waiting for a set-up command.
	input_select_t pend_r;
	input_select_t pend_nxt;
	// Values that currently steer the routing.
	input_select_t act_r;
	input_select_t act_nxt;
	// Nonvolatile copy; survives reset_n, set back to the defaults only by por_n.
	input_select_t nv_r;
	input_select_t nv_nxt;
	// Power-up sequencer.
	map_state_t state_r;
	// Registered read data and output.
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic limit_r;
	logic limit_nxt;

	// Address decode of the register port.
	wire wr_second = reg_wr && (reg_addr == `OIM_OFF_SEL_SECOND);
	wire wr_third = reg_wr && (reg_addr == `OIM_OFF_SEL_THIRD);
	wire hit_sel2 = reg_addr == `OIM_OFF_SEL_SECOND;
	wire hit_sel3 = reg_addr == `OIM_OFF_SEL_THIRD;
	wire hit_act2 = reg_addr == `OIM_OFF_ACT_SECOND;
	wire hit_act3 = reg_addr == `OIM_OFF_ACT_THIRD;

	// Reverse selector digit of the active value.
	wire [3:0] rev_code = act_r.second[`OIM_REV_DIGIT_MSB:`OIM_REV_DIGIT_LSB];
	wire code_low = rev_code <= `OIM_CODE_LOW_LAST;
	wire code_high = rev_code >= `OIM_CODE_HIGH_FIRST;
	// Terminal offset of the high-active codes; the high-active route check below indexes with it.
	wire [3:0] high_idx = rev_code - `OIM_CODE_HIGH_FIRST;
	// One-hot terminal picks; codes 7 and 8 pick nothing, so no index runs past the last terminal.
	wire [6:0] pick_low; // Terminal chosen by a low-active code.
	wire [6:0] pick_high; // Terminal chosen by a high-active code.
	genvar gi;
	generate
		for (gi = 0; gi < `OIM_TERM_COUNT; gi = gi + 1) begin : g_term
			// Low codes count up from zero and high codes from nine, in the same terminal order.
			assign pick_low[gi] = (rev_code == 4'(gi));
			assign pick_high[gi] = (rev_code == 4'(gi) + `OIM_CODE_HIGH_FIRST);
		end
	endgenerate
	// Level of the picked terminal, or zero while a forced code is in use.
	wire term_level = |((pick_low | pick_high) & io_connector_terminals);

	// Routing of the selected terminal, or a forced level.
	assign limit_nxt = (state_r != ST_RUN) ? 1'b0 :
		code_low ? ~term_level :
		code_high ? term_level :
		(rev_code == `OIM_CODE_FORCE_ON);

	// Pending values: loaded from the store at power up, then by software.
	// Reserved digits are stored as written; keeping them at default is up to software.
	assign pend_nxt.second = (state_r == ST_LOAD) ? nv_r.second :
		wr_second ? reg_wdata : pend_r.second;
	assign pend_nxt.third = (state_r == ST_LOAD) ? nv_r.third :
		wr_third ? reg_wdata : pend_r.third;

	// Active values change only at power up load or on a set-up command.
	assign act_nxt = (state_r == ST_LOAD) ? nv_r :
		setup_device_cmd ? pend_r : act_r;

	// Store copies the pending values on the nonvolatile write command.
	assign nv_nxt = nonvolatile_param_write_cmd ? pend_r : nv_r;

	// Read mux; unmapped addresses read zero.
	assign rdata_nxt = !reg_rd ? 16'h0000 :
		hit_sel2 ? pend_r.second :
		hit_sel3 ? pend_r.third :
		hit_act2 ? act_r.second :
		hit_act3 ? act_r.third : 16'h0000;

	// Nonvolatile store; it ignores reset_n so that a power cycle keeps it.
	always_ff @(posedge mclk) begin
		if (!por_n) begin
			nv_r.second <= `OIM_RST_SEL_SECOND;
			nv_r.third <= `OIM_RST_SEL_THIRD;
		end else begin
			nv_r <= nv_nxt;
		end
	end

	// Power-up sequencer; the load state lasts one cycle after every reset.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_r <= ST_LOAD;
		end else begin
			state_r <= ST_RUN;
		end
	end

	// Pending values; the defaults hold only until the load cycle copies the store in.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pend_r.second <= `OIM_RST_SEL_SECOND;
			pend_r.third <= `OIM_RST_SEL_THIRD;
		end else begin
			pend_r <= pend_nxt;
		end
	end

	// Active values; kept apart from the pending ones so that a half-written
	// configuration never steers the routing before the set-up command.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			act_r.second <= `OIM_RST_SEL_SECOND;
			act_r.third <= `OIM_RST_SEL_THIRD;
		end else begin
			act_r <= act_nxt;
		end
	end

	// Read data register; it shows zero outside the cycle after a read strobe.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Limit output register; held inactive through reset and load, so a power
	// cycle never reports an overtravel that the terminals did not show.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			limit_r <= 1'b0;
		end else begin
			limit_r <= limit_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reverse_travel_limit = limit_r;

	// Low-active routing follows the inverted terminal one cycle later.
	property p_low_route;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && code_low) |=> (reverse_travel_limit == !$past(io_connector_terminals[rev_code[2:0]]));
	endproperty
	a_low_route: assert property (p_low_route) else $error("low-active route wrong");

	// High-active routing follows the terminal one cycle later.
	property p_high_route;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && code_high) |=> (reverse_travel_limit == $past(io_connector_terminals[high_idx[2:0]]));
	endproperty
	a_high_route: assert property (p_high_route) else $error("high-active route wrong");

	// Forced codes hold the output fixed.
	property p_forced;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && (rev_code == `OIM_CODE_FORCE_ON || rev_code == `OIM_CODE_FORCE_OFF))
			|=> (reverse_travel_limit == ($past(rev_code) == `OIM_CODE_FORCE_ON));
	endproperty
	a_forced: assert property (p_forced) else $error("forced level wrong");

	// A write alone never moves the active values.
	property p_no_early;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && !setup_device_cmd) |=> (act_r == $past(act_r));
	endproperty
	a_no_early: assert property (p_no_early) else $error("active value changed without set-up");

	// Set-up command applies the pending values.
	property p_setup;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && setup_device_cmd) |=> (act_r == $past(pend_r));
	endproperty
	a_setup: assert property (p_setup) else $error("set-up did not apply values");

	// After a reset the active values equal the store two edges later.
	property p_power_cycle;
		@(posedge mclk) (!reset_n && por_n && !nonvolatile_param_write_cmd) ##1 reset_n
			|=> (act_r == $past(nv_r));
	endproperty
	a_power_cycle: assert property (p_power_cycle) else $error("store not applied after reset");

	// Store init gives the second default.
	property p_def_second;
		@(posedge mclk) !por_n |=> (nv_r.second == `OIM_RST_SEL_SECOND);
	endproperty
	a_def_second: assert property (p_def_second) else $error("second default wrong");

	// Store init gives the third default.
	property p_def_third;
		@(posedge mclk) !por_n |=> (nv_r.third == `OIM_RST_SEL_THIRD);
	endproperty
	a_def_third: assert property (p_def_third) else $error("third default wrong");

	// A write lands in the pending second value.
	property p_write_second;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && wr_second) |=> (pend_r.second == $past(reg_wdata));
	endproperty
	a_write_second: assert property (p_write_second) else $error("second write lost");

	// A write lands in the pending third value.
	property p_write_third;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && wr_third) |=> (pend_r.third == $past(reg_wdata));
	endproperty
	a_write_third: assert property (p_write_third) else $error("third write lost");

	// Without a write the pending second value holds.
	property p_keep_second;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && !wr_second) |=> (pend_r.second == $past(pend_r.second));
	endproperty
	a_keep_second: assert property (p_keep_second) else $error("pending second moved");

	// Without a write the pending third value holds.
	property p_keep_third;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_RUN && !wr_third) |=> (pend_r.third == $past(pend_r.third));
	endproperty
	a_keep_third: assert property (p_keep_third) else $error("pending third moved");

	// The store command copies both pending values.
	property p_store_write;
		@(posedge mclk)
		(por_n && nonvolatile_param_write_cmd) |=> (nv_r == $past(pend_r));
	endproperty
	a_store_write: assert property (p_store_write) else $error("store write lost");

	// The store holds through everything but its own command and por_n, reset_n included.
	property p_store_keep;
		@(posedge mclk)
		(por_n && !nonvolatile_param_write_cmd) |=> (nv_r == $past(nv_r));
	endproperty
	a_store_keep: assert property (p_store_keep) else $error("store lost its contents");

	// The load cycle copies the store into pending and active values.
	property p_load;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_LOAD) |=> (act_r == $past(nv_r) && pend_r == $past(nv_r));
	endproperty
	a_load: assert property (p_load) else $error("load cycle missed the store");

	// The output stays inactive through the load cycle.
	property p_load_quiet;
		@(posedge mclk) disable iff (!reset_n)
		(state_r == ST_LOAD) |=> !reverse_travel_limit;
	endproperty
	a_load_quiet: assert property (p_load_quiet) else $error("limit active during load");

	// Reset clears both outputs.
	property p_reset_quiet;
		@(posedge mclk)
		!reset_n |=> (!reverse_travel_limit && reg_rdata == 16'h0000);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");

	// Read data are zero unless a read was strobed.
	property p_rdata_idle;
		@(posedge mclk) disable iff (!reset_n)
		!reg_rd |=> (reg_rdata == 16'h0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

	// A read of the active second address shows the active value.
	property p_read_active;
		@(posedge mclk) disable iff (!reset_n)
		(reg_rd && hit_act2) |=> (reg_rdata == $past(act_r.second));
	endproperty
	a_read_active: assert property (p_read_active) else $error("active read wrong");

	// A read of an unmapped address gives zero.
	property p_read_unmapped;
		@(posedge mclk) disable iff (!reset_n)
		(reg_rd && !hit_sel2 && !hit_sel3 && !hit_act2 && !hit_act3) |=> (reg_rdata == 16'h0000);
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

endmodule // overtravel_input_mapper

// ---- verification/overtravel_switch_model.sv ----
// Limit switch model that drives the general-purpose input terminals of the mapper.
`timescale 1ns/10ps
module overtravel_switch_model (
	input wire logic mclk, // System clock.
	input wire logic [6:0] switch_req, // Switch states that the bench asks for.
	output logic [6:0] io_connector_terminals // Terminal levels seen by the mapper.
);
	// Open switches read high, so the terminals start released.
	initial io_connector_terminals = 7'h7f;
	// Switches move just after an edge, so the mapper never samples a level in motion.
	always @(posedge mclk) begin
		io_connector_terminals <= switch_req;
	end
endmodule // overtravel_switch_model

// ---- verification/overtravel_input_mapper_bench.sv ----
// Self-checking bench of the overtravel input mapper against a behavioural reference.
`timescale 1ns/10ps
`include "overtravel_input_mapper_map.svh"
module overtravel_input_mapper_bench;
	logic mclk, reset_n = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, setup_cmd = 1'b0, nv_cmd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [6:0] switch_req = 7'h7f, terms;
	logic limit;
	int num_errors = 0, total_checks = 0;
	logic [31:0] seed = 32'h0000_c90f; // Fixed start of the random stream.
	logic [15:0] act2, store2; // Reference copies of the active and stored second parameter.
	overtravel_input_mapper u_overtravel_input_mapper (.mclk(mclk), .reset_n(reset_n), .por_n(por_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.setup_device_cmd(setup_cmd), .nonvolatile_param_write_cmd(nv_cmd), .io_connector_terminals(terms),
		.reverse_travel_limit(limit));
	overtravel_switch_model u_overtravel_switch_model (.mclk(mclk), .switch_req(switch_req),
		.io_connector_terminals(terms));
	// The clock runs at 100 MHz.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Reference routing of the low selector digit.
	function automatic logic expect_limit(input logic [3:0] c, input logic [6:0] t);
		if (c <= 4'h6) return !t[c];
		if (c == 4'h7) return 1'b1;
		if (c == 4'h8) return 1'b0;
		return t[c - 4'h9];
	endfunction
	task automatic check_rdata(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t rdata got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check_limit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t limit got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are sampled there.
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check_rdata(reg_rdata, exp);
	endtask
	task automatic cmd(input logic nv);
		@(posedge mclk);
		if (nv) nv_cmd <= 1'b1;
		else setup_cmd <= 1'b1;
		@(posedge mclk);
		nv_cmd <= 1'b0;
		setup_cmd <= 1'b0;
	endtask
	// One edge for the switches, one for the output register, one spare.
	task automatic lim();
		logic [31:0] r;
		r = next_rand();
		@(posedge mclk);
		switch_req <= r[6:0];
		repeat (3) @(posedge mclk);
		#1 check_limit(limit, expect_limit(act2[3:0], r[6:0]));
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Cuts a hang short well beyond the roughly 400 cycles the tests need.
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		repeat (2) @(posedge mclk);
		act2 = `OIM_RST_SEL_SECOND;
		rd(`OIM_OFF_SEL_SECOND, `OIM_RST_SEL_SECOND);
		rd(`OIM_OFF_SEL_THIRD, `OIM_RST_SEL_THIRD);
		rd(`OIM_OFF_ACT_SECOND, `OIM_RST_SEL_SECOND);
		rd(`OIM_OFF_ACT_THIRD, `OIM_RST_SEL_THIRD);
		rd(4'h2, 16'h0000);
		wr(`OIM_OFF_SEL_THIRD, `OIM_RST_SEL_THIRD);
		rd(`OIM_OFF_SEL_THIRD, `OIM_RST_SEL_THIRD);
		$display("reset value test done");
		// Every selector code; the reserved digits stay at their default.
		for (int c = 0; c < 16; c++) begin
			wr(`OIM_OFF_SEL_SECOND, {12'h888, c[3:0]});
			rd(`OIM_OFF_ACT_SECOND, act2);
			lim();
			cmd(1'b0);
			act2 = {12'h888, c[3:0]};
			repeat (3) lim();
		end
		$display("selector code test done");
		// Store one code, leave another pending, then cycle power.
		wr(`OIM_OFF_SEL_SECOND, 16'h888a);
		cmd(1'b1);
		store2 = 16'h888a;
		wr(`OIM_OFF_SEL_SECOND, 16'h8883);
		@(posedge mclk) reset_n <= 1'b0;
		@(posedge mclk) reset_n <= 1'b1;
		#1 check_limit(limit, 1'b0);
		repeat (2) @(posedge mclk);
		act2 = store2;
		rd(`OIM_OFF_ACT_SECOND, act2);
		rd(`OIM_OFF_SEL_SECOND, act2);
		lim();
		$display("power cycle test done");
		tally_and_finish();
	end
endmodule // overtravel_input_mapper_bench
